// file: hdl/usx_regs.svh
// Constants of the USB stack executor and flash loader.
`ifndef USX_REGS_SVH
`define USX_REGS_SVH
`define USX_TERMINATOR 16'hFFFF
`define USX_TERM_BYTES 4
`define USX_LEN_LO_BITS 16
`define USX_LEN_HI_BITS 5
`define USX_LEN_BITS 21
`define USX_CTRL_ALIGN32_BIT 7
`define USX_SECTOR_BYTES 256
`define USX_SECTOR_XFER_BYTES 518
`define USX_SECTOR_HDR_BYTES 6
`define USX_SECTORS_SMALL 512
`define USX_SECTORS_LARGE 830
`define USX_PROG_POSITIONS 4
`define USX_CMD_STACK 8'h01
`define USX_CMD_LONGSTACK 8'h02
`define USX_CMD_FLASH 8'h03
`define USX_CMD_RESET_TOGGLE 8'h04
`endif

// file: hdl/usx_pkg.sv
// Types shared by the USB stack executor and flash loader.
package usx_pkg;
    typedef enum logic [7:0] {
        ST_IDLE = 8'b0000_0001,
        ST_LEN_LO = 8'b0000_0010,
        ST_LEN_HI = 8'b0000_0100,
        ST_EXEC = 8'b0000_1000,
        ST_WAIT_VME = 8'b0001_0000,
        ST_TERM = 8'b0010_0000,
        ST_FLASH = 8'b0100_0000,
        ST_DRAIN = 8'b1000_0000
    } usx_state_e;
    typedef logic [15:0] usx_word_t;
endpackage

// file: hdl/usx_skid.sv
// Two-entry buffer with valid and ready on both sides.
module usx_skid
    import usx_pkg::*;
#(
    parameter int WIDTH = 17
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [WIDTH-1:0] mem_ff [2];
    logic wr_ff;
    logic rd_ff;
    logic [1:0] cnt_ff;
    logic push;
    logic pop;

    assign push = in_valid && (cnt_ff != 2'd2);
    assign pop = out_ready && (cnt_ff != 2'd0);
    assign in_ready = (cnt_ff != 2'd2);
    assign out_valid = (cnt_ff != 2'd0);
    assign out_data = mem_ff[rd_ff];

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            cnt_ff <= 2'd0;
        end
        else
        begin
            if (push)
            begin
                wr_ff <= ~wr_ff;
            end
            if (pop)
            begin
                rd_ff <= ~rd_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // usx_skid

// file: hdl/usx_exec.sv
// Command front end: stack execution, reply framing and flash sector loading.
`include "usx_regs.svh"
module usx_exec
    import usx_pkg::*;
#(
    parameter int SECTOR_COUNT_MAX = `USX_SECTORS_LARGE
)
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [31:0] IN_DATA,
    input wire logic [1:0] IN_SIZE,
    input wire logic IN_VALID,
    output logic IN_READY,
    output logic [15:0] VME_CMD,
    output logic VME_CMD_VALID,
    input wire logic VME_CMD_READY,
    input wire logic VME_LAST,
    input wire logic [15:0] VME_RD_DATA,
    input wire logic VME_RD_VALID,
    output logic [15:0] OUT_DATA,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    input wire logic FIFO_FULL,
    input wire logic DAQ_MODE,
    input wire logic [7:0] GLOBAL_CTRL,
    input wire logic [3:0] ROTARY_POS,
    output logic FAIL_LED,
    output logic LOGIC_RESET,
    output logic [7:0] FLASH_DATA,
    output logic FLASH_WE,
    output logic [9:0] FLASH_SECTOR,
    output logic [7:0] FLASH_OFFSET,
    output logic [20:0] STACK_WORD_COUNT,
    output logic BUSY
);
    usx_state_e state_ff;
    logic [20:0] stack_word_count_ff;
    logic [15:0] len_lo_ff;
    logic [9:0] byte_cnt_ff;
    logic [9:0] sector_ff;
    logic [15:0] out_words_ff;
    logic [1:0] term_cnt_ff;
    logic [2:0] rot_ff;
    logic prog_mode_ff;
    logic rst_state_ff;
    logic [16:0] buf_in;
    logic buf_in_valid;
    logic buf_in_ready;
    logic [16:0] buf_out;
    logic buf_out_valid;
    logic rel_ok;
    logic pad_needed;
    logic [7:0] in_byte;

    // A byte-wide word is the command itself, wider words carry it in bits 15:8; the host may send it in any width.
    function automatic logic [7:0] cmd_of(input logic [31:0] w, input logic [1:0] sz);
        cmd_of = (sz == 2'd0) ? w[7:0] : w[15:8];
    endfunction

    assign in_byte = IN_DATA[7:0];

    // Rotary position is a pin and is synchronised before use.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            rot_ff <= 3'b000;
            prog_mode_ff <= 1'b0;
        end
        else
        begin
            rot_ff <= {rot_ff[1:0], (ROTARY_POS < 4'(`USX_PROG_POSITIONS))};
            if (rot_ff[1] == rot_ff[2])
            begin
                prog_mode_ff <= rot_ff[2];
            end
        end
    end

    assign pad_needed = GLOBAL_CTRL[`USX_CTRL_ALIGN32_BIT] && out_words_ff[0];

    always_comb
    begin
        buf_in = {1'b0, VME_RD_DATA};
        buf_in_valid = 1'b0;
        if (state_ff == ST_WAIT_VME && VME_RD_VALID)
        begin
            buf_in_valid = 1'b1;
        end
        else if (state_ff == ST_TERM)
        begin
            buf_in = {1'b1, 16'(`USX_TERMINATOR)};
            buf_in_valid = 1'b1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            state_ff <= ST_IDLE;
            stack_word_count_ff <= '0;
            len_lo_ff <= '0;
            byte_cnt_ff <= '0;
            out_words_ff <= '0;
            term_cnt_ff <= '0;
            rst_state_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    out_words_ff <= '0;
                    if (IN_VALID)
                    begin
                        case (cmd_of(IN_DATA, IN_SIZE))
                            `USX_CMD_STACK:
                            begin
                                stack_word_count_ff <= 21'(IN_DATA[31:18]);
                                state_ff <= ST_EXEC;
                            end
                            `USX_CMD_LONGSTACK:
                                state_ff <= ST_LEN_LO;
                            `USX_CMD_FLASH:
                            begin
                                byte_cnt_ff <= 10'd1;
                                state_ff <= prog_mode_ff ? ST_FLASH : ST_DRAIN;
                            end
                            `USX_CMD_RESET_TOGGLE:
                                if (prog_mode_ff)
                                begin
                                    rst_state_ff <= ~rst_state_ff;
                                end
                            default:
                                state_ff <= ST_IDLE;
                        endcase
                    end
                end
                ST_LEN_LO:
                    if (IN_VALID)
                    begin
                        len_lo_ff <= IN_DATA[15:0];
                        state_ff <= ST_LEN_HI;
                    end
                ST_LEN_HI:
                    if (IN_VALID)
                    begin
                        // The count includes the high-length word, so one is taken off.
                        stack_word_count_ff <= {IN_DATA[4:0], len_lo_ff} - 21'd1;
                        state_ff <= ST_EXEC;
                    end
                ST_EXEC:
                    if (stack_word_count_ff == '0)
                    begin
                        state_ff <= ST_WAIT_VME;
                    end
                    else if (IN_VALID && VME_CMD_READY)
                    begin
                        stack_word_count_ff <= stack_word_count_ff - 21'd1;
                    end
                ST_WAIT_VME:
                begin
                    if (VME_RD_VALID && buf_in_ready)
                    begin
                        out_words_ff <= out_words_ff + 16'd1;
                    end
                    if (VME_LAST)
                    begin
                        term_cnt_ff <= pad_needed ? 2'd3 : 2'd2;
                        state_ff <= ST_TERM;
                    end
                end
                ST_TERM:
                    if (buf_in_ready)
                    begin
                        // Two 16-bit terminator words give the 4 trailing bytes; a third is sent when 32-bit alignment needs a pad.
                        term_cnt_ff <= term_cnt_ff - 2'd1;
                        if (term_cnt_ff == 2'd1)
                        begin
                            state_ff <= ST_IDLE;
                        end
                    end
                ST_FLASH, ST_DRAIN:
                    if (IN_VALID)
                    begin
                        byte_cnt_ff <= byte_cnt_ff + 10'd1;
                        if (byte_cnt_ff == 10'(`USX_SECTOR_XFER_BYTES - 1))
                        begin
                            state_ff <= ST_IDLE;
                        end
                    end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // Flash write strobes fall on the 256 data bytes only.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            FLASH_WE <= 1'b0;
            FLASH_DATA <= '0;
            FLASH_OFFSET <= '0;
            sector_ff <= '0;
        end
        else
        begin
            FLASH_WE <= 1'b0;
            if (state_ff == ST_FLASH && IN_VALID &&
                byte_cnt_ff >= 10'(`USX_SECTOR_HDR_BYTES) &&
                byte_cnt_ff < 10'(`USX_SECTOR_HDR_BYTES + `USX_SECTOR_BYTES))
            begin
                FLASH_WE <= 1'b1;
                FLASH_DATA <= in_byte;
                FLASH_OFFSET <= 8'(byte_cnt_ff - 10'(`USX_SECTOR_HDR_BYTES));
            end
            if (state_ff == ST_FLASH && IN_VALID &&
                byte_cnt_ff == 10'(`USX_SECTOR_XFER_BYTES - 1))
            begin
                // Wraps after sector SECTOR_COUNT_MAX - 1, by default the last sector of the larger image.
                sector_ff <= (sector_ff == 10'(SECTOR_COUNT_MAX - 1)) ? '0
                             : sector_ff + 10'd1;
            end
        end
    end

    usx_skid #(.WIDTH(17)) u_skid (
        .clk(CLK),
        .rst_n(RST_N),
        .in_data(buf_in),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .out_data(buf_out),
        .out_valid(buf_out_valid),
        .out_ready(OUT_READY && !OUT_VALID && rel_ok)
    );

    // Acquisition mode holds data back until the full flag releases it.
    assign rel_ok = !DAQ_MODE || FIFO_FULL;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            OUT_VALID <= 1'b0;
            OUT_DATA <= '0;
            VME_CMD_VALID <= 1'b0;
            VME_CMD <= '0;
            IN_READY <= 1'b0;
            FAIL_LED <= 1'b0;
            LOGIC_RESET <= 1'b0;
            FLASH_SECTOR <= '0;
            STACK_WORD_COUNT <= '0;
            BUSY <= 1'b0;
        end
        else
        begin
            if (OUT_VALID)
            begin
                OUT_VALID <= 1'b0;
            end
            else if (OUT_READY && rel_ok && buf_out_valid)
            begin
                OUT_VALID <= 1'b1;
                OUT_DATA <= buf_out[15:0];
            end
            VME_CMD_VALID <= (state_ff == ST_EXEC) && IN_VALID &&
                             (stack_word_count_ff != '0) && VME_CMD_READY;
            VME_CMD <= IN_DATA[15:0];
            IN_READY <= (state_ff != ST_WAIT_VME) && (state_ff != ST_TERM);
            FAIL_LED <= prog_mode_ff;
            LOGIC_RESET <= rst_state_ff;
            FLASH_SECTOR <= sector_ff;
            STACK_WORD_COUNT <= stack_word_count_ff;
            BUSY <= (state_ff != ST_IDLE);
        end
    end
endmodule // usx_exec

// file: verif/usx_exec_monitor.sv
// Port-level assertions for the stack executor and flash loader.
module usx_exec_monitor
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic IN_VALID,
    input wire logic VME_CMD_VALID,
    input wire logic VME_LAST,
    input wire logic [15:0] OUT_DATA,
    input wire logic OUT_VALID,
    input wire logic DAQ_MODE,
    input wire logic FIFO_FULL,
    input wire logic [3:0] ROTARY_POS,
    input wire logic FAIL_LED,
    input wire logic LOGIC_RESET,
    input wire logic FLASH_WE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // The selector passes a three-flop synchroniser, so mode changes are given five cycles.
    property p_prog_on; (ROTARY_POS < 4'h4) [*5] |=> FAIL_LED; endproperty
    a_prog_on: assert property (p_prog_on) else $error("prog mode not shown");
    property p_prog_off; (ROTARY_POS >= 4'h4) [*5] |=> !FAIL_LED; endproperty
    a_prog_off: assert property (p_prog_off) else $error("prog mode shown");
    property p_flash_gate; !FAIL_LED |-> !FLASH_WE; endproperty
    a_flash_gate: assert property (p_flash_gate) else $error("flash written");
    property p_flash_src; FLASH_WE |-> $past(IN_VALID) || $past(IN_VALID, 2); endproperty
    a_flash_src: assert property (p_flash_src) else $error("flash write w/o byte");
    property p_rst_gate; $changed(LOGIC_RESET) |-> FAIL_LED; endproperty
    a_rst_gate: assert property (p_rst_gate) else $error("reset toggled");
    property p_daq_hold; DAQ_MODE && !FIFO_FULL && $past(DAQ_MODE && !FIFO_FULL) |-> !OUT_VALID;
    endproperty
    a_daq_hold: assert property (p_daq_hold) else $error("output before full");
    property p_term; VME_LAST && !DAQ_MODE |-> ##[1:40] OUT_VALID && OUT_DATA == 16'hFFFF;
    endproperty
    a_term: assert property (p_term) else $error("no terminator");
    property p_cmd_src; VME_CMD_VALID |-> $past(IN_VALID); endproperty
    a_cmd_src: assert property (p_cmd_src) else $error("command w/o word");
    c_flash: cover property (FLASH_WE);
    c_term: cover property (VME_LAST ##[1:40] OUT_VALID);
    c_toggle: cover property ($changed(LOGIC_RESET));
endmodule // usx_exec_monitor

bind usx_exec usx_exec_monitor usx_exec_monitor_i (.CLK, .RST_N, .IN_VALID, .VME_CMD_VALID,
    .VME_LAST, .OUT_DATA, .OUT_VALID, .DAQ_MODE, .FIFO_FULL, .ROTARY_POS, .FAIL_LED,
    .LOGIC_RESET, .FLASH_WE);

// file: verif/usx_host.sv
// Host reader model that collects reply words and can stall.
module usx_host
(
    input wire logic CLK,
    input wire logic [15:0] OUT_DATA,
    input wire logic OUT_VALID,
    input wire logic slow,
    output logic OUT_READY
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] got[$];
    logic ph = 1'b0;
    initial OUT_READY = 1'b1;
    // A slow host drops ready on alternate cycles so the buffer must hold words.
    always @(negedge CLK)
    begin
        ph <= !ph;
        OUT_READY <= !(slow && ph);
    end
    // The design looks at ready when it launches a word, so every valid pulse is taken.
    always @(posedge CLK)
    begin
        if (OUT_VALID === 1'b1)
            got.push_back(OUT_DATA);
    end
endmodule // usx_host

// file: verif/test_usx_exec.sv
// Self-checking bench for the stack executor and flash loader.
module test_usx_exec;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int code; int n; int nr; int x; bit al;} usx_row_s;
    usx_row_s rows[5] = '{'{1, 1, 0, 2, 0}, '{1, 3, 2, 4, 0}, '{1, 2, 1, 4, 1},
        '{2, 3, 1, 3, 0}, '{2, 1, 2, 4, 1}};
    logic CLK = 1'b0, RST_N = 1'b0, IN_VALID = 1'b0, VME_CMD_READY = 1'b1;
    logic VME_LAST = 1'b0, VME_RD_VALID = 1'b0, FIFO_FULL = 1'b0, DAQ_MODE = 1'b0, slow = 1'b0;
    logic [31:0] IN_DATA = 32'h0000_0000;
    logic [1:0] IN_SIZE = 2'h0;
    logic [15:0] VME_RD_DATA = 16'h0000;
    logic [7:0] GLOBAL_CTRL = 8'h00;
    logic [3:0] ROTARY_POS = 4'h8;
    logic IN_READY, VME_CMD_VALID, OUT_VALID, OUT_READY, FAIL_LED, LOGIC_RESET, FLASH_WE, BUSY;
    logic [15:0] VME_CMD, OUT_DATA;
    logic [7:0] FLASH_DATA, FLASH_OFFSET;
    logic [9:0] FLASH_SECTOR;
    logic [20:0] STACK_WORD_COUNT;
    logic [15:0] cmds[$];
    int bad_count = 0, n_checks = 0, cyc = 0, we_n = 0, s;
    always #25 CLK = !CLK;
    usx_exec #(.SECTOR_COUNT_MAX(2)) usx_exec_i (.CLK, .RST_N, .IN_DATA, .IN_SIZE, .IN_VALID,
        .IN_READY, .VME_CMD, .VME_CMD_VALID, .VME_CMD_READY, .VME_LAST, .VME_RD_DATA,
        .VME_RD_VALID, .OUT_DATA, .OUT_VALID, .OUT_READY, .FIFO_FULL, .DAQ_MODE, .GLOBAL_CTRL,
        .ROTARY_POS, .FAIL_LED, .LOGIC_RESET, .FLASH_DATA, .FLASH_WE, .FLASH_SECTOR,
        .FLASH_OFFSET, .STACK_WORD_COUNT, .BUSY);
    usx_host usx_host_i (.CLK, .OUT_DATA, .OUT_VALID, .slow, .OUT_READY);
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task conclude;
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Valid is only raised while ready is seen high, since words are taken on any valid.
    task put(input logic [31:0] d, input logic [1:0] z);
        while (IN_READY !== 1'b1)
        begin
            IN_VALID = 1'b0;
            @(negedge CLK);
        end
        IN_DATA = d;
        IN_SIZE = z;
        IN_VALID = 1'b1;
        @(negedge CLK);
    endtask
    task run(input int code, n, nr, x, input bit al);
        int i;
        GLOBAL_CTRL = {al, 7'h00};
        cmds.delete();
        usx_host_i.got.delete();
        if (code == 1)
            put({15'(2 * n), 17'h0_0100}, 2'h2);
        else
        begin
            put(32'h0000_0200, 2'h1);
            put(32'(n + 1), 2'h1);
            put(32'h0000_0000, 2'h1);
        end
        for (i = 0; i < n; i++)
            put(32'h0000_A000 + i, 2'h1);
        IN_VALID = 1'b0;
        while (cmds.size() < n)
            @(negedge CLK);
        for (i = 0; i < nr; i++)
        begin
            VME_RD_DATA = 16'(16'h5000 + i);
            VME_RD_VALID = 1'b1;
            @(negedge CLK);
        end
        VME_RD_VALID = 1'b0;
        VME_LAST = 1'b1;
        @(negedge CLK);
        VME_LAST = 1'b0;
        if (DAQ_MODE)
        begin
            repeat (20) @(negedge CLK);
            chk(usx_host_i.got.size(), 0);
            chk(BUSY, 32'h0000_0001);
            FIFO_FULL = 1'b1;
        end
        while (usx_host_i.got.size() < x)
            @(negedge CLK);
        repeat (8) @(negedge CLK);
        chk({BUSY, STACK_WORD_COUNT}, 32'h0000_0000);
        chk(usx_host_i.got.size(), x);
        for (i = 0; i < n; i++)
            chk(cmds[i], 32'h0000_A000 + i);
        for (i = 0; i < x; i++)
            chk(usx_host_i.got[i], i < nr ? 32'h0000_5000 + i : 32'h0000_FFFF);
    endtask
    task flash(input int t);
        int k;
        put(32'h0000_0003, 2'h0);
        for (k = 1; k < 518; k++)
            put(k >= 6 && k < 262 ? 32'(8'(k - 6) ^ 8'(t)) : 32'h0000_0000, 2'h0);
        IN_VALID = 1'b0;
        @(negedge CLK);
    endtask
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        if (VME_CMD_VALID === 1'b1)
            cmds.push_back(VME_CMD);
        if (FLASH_WE === 1'b1)
        begin
            chk({FLASH_SECTOR, FLASH_OFFSET, FLASH_DATA},
                {10'(we_n / 256 % 2), 8'(we_n), 8'(we_n ^ (we_n / 256))});
            we_n <= we_n + 1;
        end
        if (cyc == 20000)
        begin
            bad_count++;
            conclude;
        end
    end
    initial
    begin
        repeat (10) @(negedge CLK);
        chk({BUSY, OUT_VALID, VME_CMD_VALID, FLASH_WE, LOGIC_RESET}, 32'h0000_0000);
        RST_N = 1'b1;
        repeat (2) @(negedge CLK);
        foreach (rows[r])
            run(rows[r].code, rows[r].n, rows[r].nr, rows[r].x, rows[r].al);
        DAQ_MODE = 1'b1;
        slow = 1'b1;
        run(1, 2, 1, 3, 1'b0);
        DAQ_MODE = 1'b0;
        flash(0);
        put(32'h0000_0400, 2'h1);
        IN_VALID = 1'b0;
        repeat (4) @(negedge CLK);
        chk(LOGIC_RESET, 32'h0000_0000);
        ROTARY_POS = 4'h2;
        repeat (6) @(negedge CLK);
        chk(FAIL_LED, 32'h0000_0001);
        // The loader needs no spacing between sectors, so the pause is kept short here.
        for (s = 0; s < 3; s++)
            flash(s);
        repeat (10) @(negedge CLK);
        chk(we_n, 768);
        put(32'h0000_0400, 2'h1);
        IN_VALID = 1'b0;
        repeat (4) @(negedge CLK);
        chk(LOGIC_RESET, 32'h0000_0001);
        conclude;
    end
endmodule // test_usx_exec
